//--- src/fbrs_defs.vh
// Function
// - Config bit 6 picks which burst clock edge starts, outputs data, asserts wait.
// - Bit 3 clear wraps fixed bursts inside aligned length; set runs linearly.
// - Wrap 4-word: starts 0..3 give 0123, 1230, 2301, 3012.
// - No-wrap 4-word: starts 0..3 give 0123, 1234, 2345, 3456.
// - No-wrap mode holds the host off with wait until data is valid.
// - Length field bits 2:0 sets words per burst; 1h is 4, 7h continuous.
// - Continuous burst keeps delivering words until the end of address space.
// - Continuous bursts are always linear; the wrap bit is ignored.
// - Continuous code also gives the non-aligned linear 4-word orders.
// - Misaligned linear start costs one wait delay at first 16-word row crossing.
// - Length code 010b is 8 words, 011b is 16 words.
`ifndef FBRS_DEFS_VH
`define FBRS_DEFS_VH

// Register byte offsets
`define FBRS_OFS_CFG      8'h00
`define FBRS_OFS_STATUS   8'h04
`define FBRS_OFS_MADDR    8'h08
`define FBRS_OFS_MDATA    8'h0c

// Reset values
`define FBRS_CFG_RST      16'h0041
`define FBRS_MADDR_RST    8'h00

// Configuration field positions
`define FBRS_CFG_EDGE     6
`define FBRS_CFG_WRAP     3
`define FBRS_CFG_LEN_HI   2
`define FBRS_CFG_LEN_LO   0

// Length codes
`define FBRS_LEN_4        3'h1
`define FBRS_LEN_8        3'h2
`define FBRS_LEN_16       3'h3
`define FBRS_LEN_CONT     3'h7

// Word counts per fixed burst
`define FBRS_WORDS_4      8'h04
`define FBRS_WORDS_8      8'h08
`define FBRS_WORDS_16     8'h10

// Last word of the burstable space
`define FBRS_ADDR_LAST    8'hff

`endif

//--- src/fbrs_mem.v
`timescale 1ns/1ns
`default_nettype none

// Word array behind the burst port; read data is registered
module fbrs_mem (
    input  wire        mclk_i,
    input  wire        we_i,
    input  wire [7:0]  waddr_i,
    input  wire [15:0] wdata_i,
    input  wire [7:0]  raddr_i,
    output reg  [15:0] rdata_o
);

    reg [15:0] mem [0:255];

    // One write port, one registered read port
    always @(posedge mclk_i) begin
        if (we_i) begin
            mem[waddr_i] <= wdata_i;
        end
        rdata_o <= mem[raddr_i];
    end

endmodule

`default_nettype wire

//--- src/fbrs_top.v
// The Wishbone slave port and the address map were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
`include "fbrs_defs.vh"

module fbrs_top (
    input  wire        mclk_i,
    input  wire        rst_i,
    input  wire        wb_cyc_i,
    input  wire        wb_stb_i,
    input  wire        wb_we_i,
    input  wire [7:0]  wb_adr_i,
    input  wire [31:0] wb_dat_i,
    input  wire [3:0]  wb_sel_i,
    output reg  [31:0] wb_dat_o,
    output reg         wb_ack_o,
    input  wire        burst_clk_i,
    input  wire        adv_n_i,
    input  wire        ce_n_i,
    input  wire [7:0]  addr_i,
    output reg  [15:0] dq_o,
    output reg         dq_oe_o,
    output reg         wait_o
);

    // Sequencer states
    localparam [1:0] ST_IDLE   = 2'h0;
    localparam [1:0] ST_LAT    = 2'h1;
    localparam [1:0] ST_STREAM = 2'h2;
    localparam [1:0] ST_DONE   = 2'h3;

    // Words in a fixed burst; unsupported codes fall back to four
    function [7:0] fbrs_words;
        input [2:0] code;
        begin
            case (code)
                `FBRS_LEN_4:  fbrs_words = `FBRS_WORDS_4;
                `FBRS_LEN_8:  fbrs_words = `FBRS_WORDS_8;
                `FBRS_LEN_16: fbrs_words = `FBRS_WORDS_16;
                default:      fbrs_words = `FBRS_WORDS_4;
            endcase
        end
    endfunction

    // Continuous code; decides both the order and the end of a burst
    function fbrs_is_cont;
        input [2:0] code;
        begin
            fbrs_is_cont = (code == `FBRS_LEN_CONT);
        end
    endfunction

    // Next word address: linear count or wrap inside the aligned length
    function [7:0] fbrs_next;
        input [7:0] a;
        input [2:0] code;
        input       linear;
        reg   [7:0] m;
        reg   [7:0] inc;
        begin
            // Offset bits that stay inside the burst length
            m   = fbrs_words(code) - 8'h01;
            inc = a + 8'h01;
            if (linear) begin
                fbrs_next = inc;
            end else begin
                fbrs_next = (a & ~m) | (inc & m);
            end
        end
    endfunction

    // Two-flop synchronisers for every link input
    reg        clk_s1;
    reg        clk_s2;
    reg        clk_s3;
    reg        adv_n_s1;
    reg        adv_n_s2;
    reg        ce_n_s1;
    reg        ce_n_s2;
    reg [7:0]  addr_s1;
    reg [7:0]  addr_s2;

    // Software registers
    reg [15:0] read_configuration;
    reg [7:0]  mem_waddr;

    // Burst state, latched when an access starts
    reg [1:0]  state;
    reg [7:0]  cur_addr;
    reg [7:0]  word_cnt;
    reg [7:0]  burst_len;
    reg [2:0]  len_code;
    reg        cont;
    reg        linear;
    reg        misaligned;
    reg        row_delayed;
    reg        last_word;

    // Decoded strobes and burst conditions
    wire [15:0] rdata;
    wire        clk_rise;
    wire        clk_fall;
    wire        act_edge;
    wire        wb_req;
    wire        wb_new;
    wire        wb_wr;
    wire        mem_we;
    wire        burst_done;
    wire        row_hold;
    wire [2:0]  cfg_len;
    wire        cfg_linear;

    always @(posedge mclk_i) begin
        if (rst_i) begin
            // Idle pin levels, so no false edge follows reset
            clk_s1   <= 1'b0;
            clk_s2   <= 1'b0;
            clk_s3   <= 1'b0;
            adv_n_s1 <= 1'b1;
            adv_n_s2 <= 1'b1;
            ce_n_s1  <= 1'b1;
            ce_n_s2  <= 1'b1;
            addr_s1  <= 8'h00;
            addr_s2  <= 8'h00;
        end else begin
            // Clock and strobes share one delay, so they stay aligned
            clk_s1   <= burst_clk_i;
            clk_s2   <= clk_s1;
            clk_s3   <= clk_s2;
            adv_n_s1 <= adv_n_i;
            adv_n_s2 <= adv_n_s1;
            ce_n_s1  <= ce_n_i;
            ce_n_s2  <= ce_n_s1;
            addr_s1  <= addr_i;
            addr_s2  <= addr_s1;
        end
    end

    // Edge detection on the synchronised burst clock
    assign clk_rise = clk_s2 & ~clk_s3;
    assign clk_fall = ~clk_s2 & clk_s3;
    assign act_edge = read_configuration[`FBRS_CFG_EDGE] ?
                      clk_rise : clk_fall;

    // Bus decode
    assign wb_req = wb_cyc_i & wb_stb_i;
    assign wb_new = wb_req & ~wb_ack_o;
    assign wb_wr  = wb_req & wb_we_i & wb_ack_o;
    assign mem_we = wb_wr & (wb_adr_i == `FBRS_OFS_MDATA);

    // Continuous length forces linear order
    assign cfg_len    = read_configuration[`FBRS_CFG_LEN_HI:`FBRS_CFG_LEN_LO];
    assign cfg_linear = read_configuration[`FBRS_CFG_WRAP] |
                        fbrs_is_cont(cfg_len);

    // End of burst: word count for fixed, last address for continuous
    assign burst_done = cont ? last_word :
                        (word_cnt == burst_len);

    // One extra wait at the first row crossing of a misaligned start
    assign row_hold = linear & misaligned & ~row_delayed &
                      (cur_addr[3:0] == 4'h0);

    // Bus slave: one-cycle answer, ack dropped after one cycle
    always @(posedge mclk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= wb_new;
            // Read data stands until the next read
            if (wb_new & ~wb_we_i) begin
                case (wb_adr_i)
                    `FBRS_OFS_CFG:
                        wb_dat_o <= {16'h0000, read_configuration};
                    `FBRS_OFS_STATUS:
                        wb_dat_o <= {8'h00, dq_oe_o, wait_o, 4'h0,
                                     state, word_cnt, cur_addr};
                    `FBRS_OFS_MADDR:
                        wb_dat_o <= {24'h000000, mem_waddr};
                    default:
                        wb_dat_o <= 32'h0000_0000;
                endcase
            end
        end
    end

    // Software registers; writes land at the acknowledging edge
    always @(posedge mclk_i) begin
        if (rst_i) begin
            read_configuration <= `FBRS_CFG_RST;
            mem_waddr          <= `FBRS_MADDR_RST;
        end else if (wb_wr) begin
            case (wb_adr_i)
                // Configuration honours byte lanes 0 and 1
                `FBRS_OFS_CFG: begin
                    if (wb_sel_i[0]) begin
                        read_configuration[7:0] <= wb_dat_i[7:0];
                    end
                    if (wb_sel_i[1]) begin
                        read_configuration[15:8] <= wb_dat_i[15:8];
                    end
                end
                `FBRS_OFS_MADDR: begin
                    if (wb_sel_i[0]) begin
                        mem_waddr <= wb_dat_i[7:0];
                    end
                end
                // Auto-increment lets software stream a table in
                `FBRS_OFS_MDATA: begin
                    mem_waddr <= mem_waddr + 8'h01;
                end
                default: begin
                    mem_waddr <= mem_waddr;
                end
            endcase
        end
    end

    // Burst sequencer; every pin change lines up with an active edge
    always @(posedge mclk_i) begin
        if (rst_i) begin
            // Pins released, nothing in flight
            state       <= ST_IDLE;
            cur_addr    <= 8'h00;
            word_cnt    <= 8'h00;
            burst_len   <= `FBRS_WORDS_4;
            len_code    <= `FBRS_LEN_4;
            cont        <= 1'b0;
            linear      <= 1'b0;
            misaligned  <= 1'b0;
            row_delayed <= 1'b0;
            last_word   <= 1'b0;
            dq_o        <= 16'h0000;
            dq_oe_o     <= 1'b0;
            wait_o      <= 1'b0;
        end else if (act_edge) begin
            if (ce_n_s2) begin
                // Deselect aborts any burst
                state   <= ST_IDLE;
                dq_oe_o <= 1'b0;
                wait_o  <= 1'b0;
            end else if (!adv_n_s2) begin
                // New access: latch address and settings
                state       <= ST_LAT;
                cur_addr    <= addr_s2;
                word_cnt    <= 8'h00;
                len_code    <= cfg_len;
                burst_len   <= fbrs_words(cfg_len);
                cont        <= fbrs_is_cont(cfg_len);
                linear      <= cfg_linear;
                misaligned  <= (addr_s2[1:0] != 2'h0);
                row_delayed <= 1'b0;
                last_word   <= 1'b0;
                dq_oe_o     <= 1'b1;
                wait_o      <= 1'b1;
            end else begin
                // Burst in progress: stream, stall or finish
                case (state)
                    ST_LAT, ST_STREAM: begin
                        if (state == ST_STREAM && burst_done) begin
                            state   <= ST_DONE;
                            dq_oe_o <= 1'b0;
                            wait_o  <= 1'b0;
                        end else if (state == ST_STREAM && row_hold) begin
                            // Data held, host stalled one edge
                            row_delayed <= 1'b1;
                            wait_o      <= 1'b1;
                        end else begin
                            state     <= ST_STREAM;
                            dq_o      <= rdata;
                            wait_o    <= 1'b0;
                            word_cnt  <= word_cnt + 8'h01;
                            last_word <= (cur_addr == `FBRS_ADDR_LAST);
                            cur_addr  <= fbrs_next(cur_addr, len_code,
                                                   linear);
                        end
                    end
                    ST_DONE: begin
                        // Count or last address reached; quiet until a new access
                        dq_oe_o <= 1'b0;
                        wait_o  <= 1'b0;
                    end
                    default: begin
                        // Idle: pins stay released
                        dq_oe_o <= 1'b0;
                        wait_o  <= 1'b0;
                    end
                endcase
            end
        end
    end

    // Read port follows the current word; edges are far apart,
    // so the one-cycle read latency never shows on the pins
    fbrs_mem u_mem (
        .mclk_i  (mclk_i),
        .we_i    (mem_we),
        .waddr_i (mem_waddr),
        .wdata_i (wb_dat_i[15:0]),
        .raddr_i (cur_addr),
        .rdata_o (rdata)
    );

endmodule

`default_nettype wire

//--- tb/fbrs_monitor.sv
`timescale 1ns/1ns
`default_nettype none

// Watches bus and link outputs of the top at its ports
module fbrs_monitor (
    input wire logic        mclk_i,
    input wire logic        rst_i,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [7:0]  wb_adr_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic [15:0] dq_o,
    input wire logic        dq_oe_o,
    input wire logic        wait_o
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (rst_i);
    // Fresh request only; an acked cycle is not asked again
    wire req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire unmapped = !(wb_adr_i inside {8'h00, 8'h04, 8'h08, 8'h0c});
    // Link edges sit 7 to 9 mclk apart after resync jitter
    sequence s_wait_hold;
        wait_o [*6];
    endsequence
    sequence s_wait_free;
        !wait_o;
    endsequence
    a_ack_next: assert property (req |=> wb_ack_o)
        else $error("ack missing after request");
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    a_ack_cause: assert property (!req |=> !wb_ack_o)
        else $error("ack without request");
    a_unmapped_zero: assert property (wb_ack_o && !wb_we_i && unmapped
        |-> wb_dat_o == 32'h0) else $error("unmapped read not zero");
    a_wait_oe: assert property (wait_o |-> dq_oe_o)
        else $error("wait outside a burst");
    a_oe_first_wait: assert property ($rose(dq_oe_o) |-> wait_o)
        else $error("burst start without hold-off");
    a_wait_one_edge: assert property ($rose(wait_o) |->
        s_wait_hold ##[1:6] s_wait_free) else $error("wait length wrong");
    a_dq_hold_wait: assert property (wait_o && $past(wait_o)
        |-> $stable(dq_o)) else $error("data moved during wait");
endmodule

bind fbrs_top fbrs_monitor u_mon (.mclk_i(mclk_i), .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .dq_o(dq_o), .dq_oe_o(dq_oe_o), .wait_o(wait_o));

`default_nettype wire

//--- tb/fbrs_host.sv
`timescale 1ns/1ns
`default_nettype none

// Burst host; link clock runs only inside a frame
module fbrs_host (
    input  wire logic        mclk_i,
    output logic             burst_clk_o,
    output logic             adv_n_o,
    output logic             ce_n_o,
    output logic [7:0]       addr_o,
    input  wire logic [15:0] dq_i,
    input  wire logic        dq_oe_i,
    input  wire logic        wait_i
);
    event        got;
    logic [15:0] word;
    logic        hung;
    int          nwords;
    int          nwaits;
    initial begin
        burst_clk_o = 1'b0;
        adv_n_o = 1'b1;
        ce_n_o = 1'b1;
        addr_o = 8'h00;
        hung = 1'b0;
    end
    // Half a link period is four mclk; pins move just after an edge
    // and are looked at just before each active edge
    task automatic burst(input logic [7:0] a, input logic rise);
        int k;
        nwords = 0;
        nwaits = 0;
        @(posedge mclk_i);
        burst_clk_o <= !rise;
        repeat (4) @(posedge mclk_i);
        ce_n_o <= 1'b0;
        adv_n_o <= 1'b0;
        addr_o <= a;
        repeat (4) @(posedge mclk_i);
        for (k = 0; k < 300; k++) begin
            burst_clk_o <= rise;
            repeat (4) @(posedge mclk_i);
            adv_n_o <= 1'b1;
            // Released lines show the inverse, not the old address
            addr_o <= ~a;
            burst_clk_o <= !rise;
            repeat (4) @(posedge mclk_i);
            if (k > 0 && !dq_oe_i)
                break;
            if (wait_i)
                nwaits++;
            else if (dq_oe_i) begin
                word = dq_i;
                nwords++;
                -> got;
            end
        end
        // A frame that never ends is a hang
        hung = (k >= 300);
        ce_n_o <= 1'b1;
    endtask
endmodule

`default_nettype wire

//--- tb/fbrs_top_bench.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, s) begin checks_done++; if ((e) !== (s)) begin \
    error_cnt++; $display("CHECK FAILED %s exp %h got %h", n, e, s); end end

module fbrs_top_bench;
    logic        mclk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0;
    logic [7:0]  adr = 8'h00;
    logic [31:0] wdat = 32'h0, rdat;
    logic [15:0] mem [256], ew, q [$];
    wire  [31:0] dat_o;
    wire  [15:0] dq;
    wire  [7:0]  addr;
    wire         ack, bclk, adv_n, ce_n, oe, wt;
    int          error_cnt = 0, checks_done = 0;

    fbrs_top u_dut (.mclk_i(mclk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(wdat),
        .wb_sel_i(4'hf), .wb_dat_o(dat_o), .wb_ack_o(ack),
        .burst_clk_i(bclk), .adv_n_i(adv_n), .ce_n_i(ce_n), .addr_i(addr),
        .dq_o(dq), .dq_oe_o(oe), .wait_o(wt));
    fbrs_host u_host (.mclk_i(mclk_i), .burst_clk_o(bclk), .adv_n_o(adv_n),
        .ce_n_o(ce_n), .addr_o(addr), .dq_i(dq), .dq_oe_i(oe), .wait_i(wt));

    initial forever #5 mclk_i = ~mclk_i;

    task automatic tally_and_finish;
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // Classic cycle; held until ack is seen at a rising edge
    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
        int t;
        @(posedge mclk_i);
        {cyc, stb, we, adr, wdat} <= {2'b11, w, a, d};
        t = 0;
        do begin @(posedge mclk_i); t++; end
        while (ack !== 1'b1 && t < 20);
        if (t >= 20) begin error_cnt++; tally_and_finish; end
        rdat = dat_o;
        {cyc, stb} <= 2'b00;
    endtask

    function automatic logic [7:0] nxt(input logic [7:0] s, input int i,
                                       input int n, input logic lin);
        return lin ? 8'(s + i) : 8'((s & ~(n - 1)) | ((s + i) & (n - 1)));
    endfunction

    // Oldest note meets each word the host takes
    always @(u_host.got) begin
        ew = q.size() > 0 ? q.pop_front() : 16'hxxxx;
        `CHK("burst word", ew, u_host.word)
    end

    initial begin
        int i, j, n, k;
        logic [2:0] code, codes [5] = '{3'h1, 3'h2, 3'h3, 3'h7, 3'h5};
        logic wrp, rise, lin;
        logic [7:0] s, a;
        void'($urandom(57233));
        repeat (5) @(posedge mclk_i);
        rst_i <= 1'b0;
        wb(1'b0, 8'h00, 32'h0);
        `CHK("cfg reset", 32'h0000_0041, rdat)
        wb(1'b0, 8'h10, 32'h0);
        `CHK("unmapped read", 32'h0, rdat)
        wb(1'b1, 8'h08, 32'h0000_00a5);
        wb(1'b0, 8'h08, 32'h0);
        `CHK("maddr readback", 32'h0000_00a5, rdat)
        wb(1'b1, 8'h08, 32'h0);
        for (i = 0; i < 256; i++) begin
            mem[i] = 16'($urandom);
            wb(1'b1, 8'h0c, {16'h0, mem[i]});
        end
        // First eight: every 4-word start, wrap then linear, odd starts on the rising edge, even on the falling;
        // code 5 is not a documented length and falls back to four words
        for (i = 0; i < 24; i++) begin
            code = i < 8 ? 3'h1 : codes[i % 5];
            wrp = i < 8 ? i >= 4 : 1'($urandom);
            rise = i < 8 ? i[0] : 1'($urandom);
            s = i < 8 ? 8'(i % 4) : 8'($urandom);
            n = code == 3'h7 ? 256 - s :
                (code == 3'h2 || code == 3'h3) ? 4 << (code - 1) : 4;
            lin = wrp || code == 3'h7;
            k = 1;
            for (j = 0; j < n; j++) begin
                a = nxt(s, j, n, lin);
                q.push_back(mem[a]);
                if (lin && s[1:0] != 2'h0 && j > 0 && a[3:0] == 4'h0)
                    k = 2;
            end
            wb(1'b1, 8'h00, {25'h0, rise, 2'h0, wrp, code});
            u_host.burst(s, rise);
            if (u_host.hung) begin
                error_cnt++;
                tally_and_finish;
            end
            `CHK("word count", n, u_host.nwords)
            `CHK("wait count", k, u_host.nwaits)
            `CHK("notes left", 0, q.size())
        end
        tally_and_finish;
    end
endmodule

`default_nettype wire
